// file: include/aos_pkg.sv
package aos_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int AOS_ACC_COUNT = 32;
  localparam int AOS_IDX_W = 5;
  localparam int AOS_DATA_W = 16;
  localparam int AOS_AP_COUNT = 4;
  localparam int AOS_ADDR_COUNT = 4;
  localparam int AOS_FLAG_COUNT = 13;
  localparam logic [4:0] AOS_OFFSET_STEP = 5'h10;
  localparam logic [15:0] AOS_BYTE_MASK = 16'h00ff;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] AOS_OFF_AP0 = 8'h00;
  localparam logic [7:0] AOS_OFF_INSTR = 8'h10;
  localparam logic [7:0] AOS_OFF_ACC_INDEX = 8'h14;
  localparam logic [7:0] AOS_OFF_ACC_DATA = 8'h18;
  localparam logic [7:0] AOS_OFF_MEM_OPERAND = 8'h1c;
  localparam logic [7:0] AOS_OFF_FLAGS = 8'h20;
  localparam logic [7:0] AOS_OFF_STATUS = 8'h24;
  localparam logic [7:0] AOS_OFF_ADDR0 = 8'h28;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] AOS_RST_WORD = 16'h0000;
  localparam logic [31:0] AOS_RST_INSTR = 32'h0000_0000;
  localparam logic [10:0] AOS_RST_FLAGS = 11'h000;

  // ----------------------------------------------------------------
  // Instruction word field positions
  // ----------------------------------------------------------------
  localparam int AOS_F_OP_LSB = 0;
  localparam int AOS_F_APSEL_LSB = 4;
  localparam int AOS_F_SRC_OFF = 6;
  localparam int AOS_F_DST_OFF = 7;
  localparam int AOS_F_SRC_OFF_N = 8;
  localparam int AOS_F_SIZE8 = 9;
  localparam int AOS_F_PMOD_LSB = 10;
  localparam int AOS_F_CC_LSB = 12;
  localparam int AOS_F_NOT = 17;
  localparam int AOS_F_FLG = 18;
  localparam int AOS_F_INV = 19;
  localparam int AOS_F_FSRC_LSB = 20;
  localparam int AOS_F_RSEL_LSB = 28;

  // ----------------------------------------------------------------
  // Flag vector bit positions
  // ----------------------------------------------------------------
  localparam int AOS_FL_ZF = 0;
  localparam int AOS_FL_SF = 1;
  localparam int AOS_FL_CF = 2;
  localparam int AOS_FL_OF = 3;
  localparam int AOS_FL_RCF = 4;
  localparam int AOS_FL_RZF = 5;
  localparam int AOS_FL_TF1 = 6;
  localparam int AOS_FL_TF2 = 7;
  localparam int AOS_FL_TAG = 8;
  localparam int AOS_FL_XZF = 9;
  localparam int AOS_FL_XSF = 10;
  localparam int AOS_FL_IN1 = 11;
  localparam int AOS_FL_IN2 = 12;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    AOS_OP_ADD = 4'b0000,
    AOS_OP_LOAD_MEM = 4'b0001,
    AOS_OP_MOVE_ACC = 4'b0010,
    AOS_OP_BRANCH = 4'b0011,
    AOS_OP_TEST_FLAG = 4'b0100,
    AOS_OP_FLAG_MOVE = 4'b0101
  } aos_op_t;

  typedef enum logic [1:0] {
    AOS_PM_NONE = 2'b00,
    AOS_PM_NEXT_A = 2'b01,
    AOS_PM_RMOD = 2'b10
  } aos_pmod_t;

  typedef enum logic [4:0] {
    AOS_CC_ZF = 5'b00000, AOS_CC_SF = 5'b00001, AOS_CC_CF = 5'b00010,
    AOS_CC_B = 5'b00011, AOS_CC_A = 5'b00100, AOS_CC_G = 5'b00101,
    AOS_CC_E = 5'b00110, AOS_CC_OF = 5'b00111, AOS_CC_L = 5'b01000,
    AOS_CC_RCF = 5'b01001, AOS_CC_RA = 5'b01010, AOS_CC_RE = 5'b01011,
    AOS_CC_TF1 = 5'b01100, AOS_CC_TF2 = 5'b01101, AOS_CC_TAG = 5'b01110,
    AOS_CC_IN1 = 5'b01111, AOS_CC_IN2 = 5'b10000, AOS_CC_XZF = 5'b10001,
    AOS_CC_XSF = 5'b10010, AOS_CC_XG = 5'b10011
  } aos_cc_t;

  typedef enum logic [1:0] {
    AOS_ST_IDLE = 2'b00,
    AOS_ST_READ = 2'b01,
    AOS_ST_EXEC = 2'b10
  } aos_state_t;

endpackage

// file: hw/aos_acc_ram.sv
`timescale 1ns/1ps
module aos_acc_ram
  import aos_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [AOS_IDX_W-1:0] wr_addr,
  input wire logic [AOS_DATA_W-1:0] wr_data,
  input wire logic [AOS_IDX_W-1:0] rd_addr_a,
  input wire logic [AOS_IDX_W-1:0] rd_addr_b,
  output logic [AOS_DATA_W-1:0] rd_data_a,
  output logic [AOS_DATA_W-1:0] rd_data_b
);

  // ----------------------------------------------------------------
  // Accumulator array, two registered read ports
  // ----------------------------------------------------------------
  logic [AOS_DATA_W-1:0] mem [AOS_ACC_COUNT];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_a <= AOS_RST_WORD;
      rd_data_b <= AOS_RST_WORD;
    end else begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule

// file: hw/aos_cond_eval.sv
`timescale 1ns/1ps
module aos_cond_eval
  import aos_pkg::*;
(
  input wire logic [4:0] cc,
  input wire logic negate,
  input wire logic [AOS_FLAG_COUNT-1:0] flags,
  output logic cond_true
);

  // ----------------------------------------------------------------
  // Positive condition, then optional inversion
  // ----------------------------------------------------------------
  logic pos;

  always_comb begin
    pos = 1'b0;
    unique case (cc)
      AOS_CC_ZF: pos = flags[AOS_FL_ZF];
      AOS_CC_SF: pos = flags[AOS_FL_SF];
      AOS_CC_CF: pos = flags[AOS_FL_CF];
      AOS_CC_B: pos = !flags[AOS_FL_ZF] && !flags[AOS_FL_CF];
      AOS_CC_A: pos = !flags[AOS_FL_ZF] && flags[AOS_FL_CF];
      AOS_CC_G: pos = flags[AOS_FL_ZF] && !flags[AOS_FL_SF];
      AOS_CC_E: pos = flags[AOS_FL_ZF] && !flags[AOS_FL_OF];
      AOS_CC_OF: pos = flags[AOS_FL_OF];
      AOS_CC_L: pos = !flags[AOS_FL_ZF] && flags[AOS_FL_SF];
      AOS_CC_RCF: pos = flags[AOS_FL_RCF];
      AOS_CC_RA: pos = !flags[AOS_FL_RZF] && flags[AOS_FL_RCF];
      AOS_CC_RE: pos = flags[AOS_FL_RZF];
      AOS_CC_TF1: pos = flags[AOS_FL_TF1];
      AOS_CC_TF2: pos = flags[AOS_FL_TF2];
      AOS_CC_TAG: pos = flags[AOS_FL_TAG];
      AOS_CC_IN1: pos = flags[AOS_FL_IN1];
      AOS_CC_IN2: pos = flags[AOS_FL_IN2];
      AOS_CC_XZF: pos = flags[AOS_FL_XZF];
      AOS_CC_XSF: pos = flags[AOS_FL_XSF];
      AOS_CC_XG: pos = !flags[AOS_FL_XZF] && !flags[AOS_FL_XSF];
      default: pos = 1'b0;
    endcase
  end

  // Negated codes use the inverse of the positive combination
  assign cond_true = pos ^ negate;

endmodule

// file: hw/aos_decoder.sv
`timescale 1ns/1ps
module aos_decoder
  import aos_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_line1,
  input wire logic in_line2
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [AOS_IDX_W-1:0] plain_index(input logic [AOS_DATA_W-1:0] ptr);
    plain_index = ptr[AOS_IDX_W-1:0];
  endfunction

  function automatic logic [AOS_IDX_W-1:0] offset_index(input logic [AOS_DATA_W-1:0] ptr);
    offset_index = ptr[AOS_IDX_W-1:0] + AOS_OFFSET_STEP;
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] base, input int count);
    reg_hit = (addr >= base) && (addr < 8'(int'(base) + 4 * count)) && (addr[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [AOS_DATA_W-1:0] acc_pointer [AOS_AP_COUNT];
  logic [AOS_DATA_W-1:0] addr_reg [AOS_ADDR_COUNT];
  logic [31:0] instr;
  logic [AOS_IDX_W-1:0] acc_index;
  logic [AOS_DATA_W-1:0] mem_operand;
  logic [10:0] flags_sw;
  logic branch_taken;
  aos_state_t state;
  aos_state_t next_state;
  logic in1_meta;
  logic in1_sync;
  logic in2_meta;
  logic in2_sync;
  logic [AOS_FLAG_COUNT-1:0] flag_vec;
  logic setup_phase;
  logic wr_access;
  logic busy;
  logic map_hit;
  logic [31:0] read_mux;
  aos_op_t op;
  aos_pmod_t pmod;
  logic [1:0] ap_sel;
  logic [1:0] r_sel;
  logic [AOS_DATA_W-1:0] cur_ptr;
  logic [AOS_IDX_W-1:0] sel_accumulator;
  logic [AOS_IDX_W-1:0] off_accumulator;
  logic src_use_offset;
  logic [AOS_IDX_W-1:0] src_idx;
  logic [AOS_IDX_W-1:0] dst_idx;
  logic [AOS_DATA_W-1:0] src_data;
  logic [AOS_DATA_W-1:0] dst_data;
  logic [AOS_DATA_W:0] sum;
  logic [AOS_DATA_W-1:0] mem_value;
  logic [AOS_DATA_W-1:0] result;
  logic result_we;
  logic cond_true;
  logic flag_operand;
  logic exec;
  logic ram_we;
  logic [AOS_IDX_W-1:0] ram_waddr;
  logic [AOS_DATA_W-1:0] ram_wdata;
  logic [AOS_IDX_W-1:0] ram_raddr_a;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in1_meta <= 1'b0;
      in1_sync <= 1'b0;
      in2_meta <= 1'b0;
      in2_sync <= 1'b0;
    end else begin
      in1_meta <= in_line1;
      in1_sync <= in1_meta;
      in2_meta <= in_line2;
      in2_sync <= in2_meta;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign busy = (state != AOS_ST_IDLE);
  assign pready = 1'b1;
  assign map_hit = reg_hit(paddr, AOS_OFF_AP0, AOS_AP_COUNT)
                || reg_hit(paddr, AOS_OFF_INSTR, 6)
                || reg_hit(paddr, AOS_OFF_ADDR0, AOS_ADDR_COUNT);
  assign pslverr = psel && penable && !map_hit;
  assign flag_vec = {in2_sync, in1_sync, flags_sw};

  always_comb begin
    read_mux = 32'h0000_0000;
    if (reg_hit(paddr, AOS_OFF_AP0, AOS_AP_COUNT)) begin
      read_mux[AOS_DATA_W-1:0] = acc_pointer[paddr[3:2]];
    end else if (reg_hit(paddr, AOS_OFF_ADDR0, AOS_ADDR_COUNT)) begin
      read_mux[AOS_DATA_W-1:0] = addr_reg[2'(paddr[5:2] - 4'h a)];
    end else begin
      unique case (paddr)
        AOS_OFF_INSTR: read_mux = instr;
        AOS_OFF_ACC_INDEX: read_mux[AOS_IDX_W-1:0] = acc_index;
        AOS_OFF_ACC_DATA: read_mux[AOS_DATA_W-1:0] = src_data;
        AOS_OFF_MEM_OPERAND: read_mux[AOS_DATA_W-1:0] = mem_operand;
        AOS_OFF_FLAGS: read_mux[AOS_FLAG_COUNT-1:0] = flag_vec;
        AOS_OFF_STATUS: read_mux = {11'h000, dst_idx, 3'h0, src_idx, 6'h00, branch_taken, busy};
        default: read_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data is captured in the setup cycle and stands in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : read_mux;
    end
  end

  // ----------------------------------------------------------------
  // Instruction field decode
  // ----------------------------------------------------------------
  assign op = aos_op_t'(instr[AOS_F_OP_LSB +: 4]);
  assign pmod = aos_pmod_t'(instr[AOS_F_PMOD_LSB +: 2]);
  assign ap_sel = instr[AOS_F_APSEL_LSB +: 2];
  assign r_sel = instr[AOS_F_RSEL_LSB +: 2];
  assign cur_ptr = acc_pointer[ap_sel];
  assign sel_accumulator = plain_index(cur_ptr);
  assign off_accumulator = offset_index(cur_ptr);

  always_comb begin
    if (op == AOS_OP_MOVE_ACC) begin
      src_use_offset = !instr[AOS_F_SRC_OFF_N];
    end else begin
      src_use_offset = instr[AOS_F_SRC_OFF];
    end
  end

  assign src_idx = src_use_offset ? off_accumulator : sel_accumulator;
  assign dst_idx = instr[AOS_F_DST_OFF] ? off_accumulator : sel_accumulator;

  // ----------------------------------------------------------------
  // Sequencer: read operands, then execute
  // ----------------------------------------------------------------
  assign exec = (state == AOS_ST_EXEC);

  always_comb begin
    next_state = state;
    unique case (state)
      AOS_ST_IDLE: begin
        if (wr_access && paddr == AOS_OFF_INSTR) begin
          next_state = AOS_ST_READ;
        end
      end
      AOS_ST_READ: next_state = AOS_ST_EXEC;
      AOS_ST_EXEC: next_state = AOS_ST_IDLE;
      default: next_state = AOS_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= AOS_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= AOS_RST_INSTR;
    end else if (!busy && wr_access && paddr == AOS_OFF_INSTR) begin
      instr <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator storage
  // ----------------------------------------------------------------
  assign ram_raddr_a = busy ? src_idx : acc_index;
  assign ram_we = exec ? result_we : (!busy && wr_access && paddr == AOS_OFF_ACC_DATA);
  assign ram_waddr = exec ? dst_idx : acc_index;
  assign ram_wdata = exec ? result : pwdata[AOS_DATA_W-1:0];

  aos_acc_ram u_acc_ram (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ram_we),
    .wr_addr(ram_waddr),
    .wr_data(ram_wdata),
    .rd_addr_a(ram_raddr_a),
    .rd_addr_b(dst_idx),
    .rd_data_a(src_data),
    .rd_data_b(dst_data)
  );

  // ----------------------------------------------------------------
  // Execute datapath
  // ----------------------------------------------------------------
  assign sum = {1'b0, dst_data} + {1'b0, src_data};
  assign mem_value = instr[AOS_F_SIZE8] ? (mem_operand & AOS_BYTE_MASK) : mem_operand;
  assign flag_operand = flag_vec[instr[AOS_F_FSRC_LSB +: 4]] ^ instr[AOS_F_INV];

  always_comb begin
    result = AOS_RST_WORD;
    result_we = 1'b0;
    unique case (op)
      AOS_OP_ADD: begin
        result = sum[AOS_DATA_W-1:0];
        result_we = 1'b1;
      end
      AOS_OP_LOAD_MEM: begin
        result = mem_value;
        result_we = 1'b1;
      end
      AOS_OP_MOVE_ACC: begin
        result = src_data;
        result_we = 1'b1;
      end
      default: begin
        result = AOS_RST_WORD;
        result_we = 1'b0;
      end
    endcase
  end

  aos_cond_eval u_cond_eval (
    .cc(instr[AOS_F_CC_LSB +: 5]),
    .negate(instr[AOS_F_NOT]),
    .flags(flag_vec),
    .cond_true(cond_true)
  );

  // ----------------------------------------------------------------
  // Status flags: execute updates win over software writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_sw <= AOS_RST_FLAGS;
    end else if (exec && op == AOS_OP_ADD) begin
      flags_sw[AOS_FL_ZF] <= (sum[AOS_DATA_W-1:0] == AOS_RST_WORD);
      flags_sw[AOS_FL_SF] <= sum[AOS_DATA_W-1];
      flags_sw[AOS_FL_CF] <= sum[AOS_DATA_W];
      flags_sw[AOS_FL_OF] <= (dst_data[AOS_DATA_W-1] == src_data[AOS_DATA_W-1])
                          && (sum[AOS_DATA_W-1] != dst_data[AOS_DATA_W-1]);
    end else if (exec && op == AOS_OP_TEST_FLAG) begin
      flags_sw[AOS_FL_TF1 + int'(instr[AOS_F_FLG])] <= cond_true;
    end else if (exec && op == AOS_OP_FLAG_MOVE) begin
      flags_sw[AOS_FL_TF1 + int'(instr[AOS_F_FLG])] <= flag_operand;
    end else if (!busy && wr_access && paddr == AOS_OFF_FLAGS) begin
      flags_sw <= pwdata[10:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch_taken <= 1'b0;
    end else if (exec && op == AOS_OP_BRANCH) begin
      branch_taken <= cond_true;
    end
  end

  // ----------------------------------------------------------------
  // Software-loaded words
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_index <= 5'h00;
      mem_operand <= AOS_RST_WORD;
    end else if (!busy && wr_access) begin
      if (paddr == AOS_OFF_ACC_INDEX) begin
        acc_index <= pwdata[AOS_IDX_W-1:0];
      end
      if (paddr == AOS_OFF_MEM_OPERAND) begin
        mem_operand <= pwdata[AOS_DATA_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pointer and address registers with post-modify
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < AOS_AP_COUNT; i++) begin : g_ap
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc_pointer[i] <= AOS_RST_WORD;
        end else if (exec && pmod == AOS_PM_NEXT_A && ap_sel == 2'(i)) begin
          acc_pointer[i] <= acc_pointer[i] + 16'h0001;
        end else if (!busy && wr_access && paddr == 8'(int'(AOS_OFF_AP0) + 4 * i)) begin
          acc_pointer[i] <= pwdata[AOS_DATA_W-1:0];
        end
      end
    end
    for (genvar j = 0; j < AOS_ADDR_COUNT; j++) begin : g_addr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          addr_reg[j] <= AOS_RST_WORD;
        end else if (exec && pmod == AOS_PM_RMOD && r_sel == 2'(j)) begin
          addr_reg[j] <= addr_reg[j] + 16'h0001;
        end else if (!busy && wr_access && paddr == 8'(int'(AOS_OFF_ADDR0) + 4 * j)) begin
          addr_reg[j] <= pwdata[AOS_DATA_W-1:0];
        end
      end
    end
  endgenerate

endmodule

// file: tb/aos_decoder_monitor.sv
`timescale 1ns/1ps
module aos_decoder_monitor
  import aos_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_line1,
  input wire logic in_line2
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_setup;
  logic acc_ph;
  logic bad_adr;
  assign rd_setup = psel && !penable && !pwrite;
  assign acc_ph = psel && penable;
  assign bad_adr = paddr >= 8'h38 || paddr[1:0] != 2'b00;
  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_phase; pslverr |-> acc_ph; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_err_map; acc_ph && bad_adr |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("no error on bad address");
  property p_no_err; acc_ph && !bad_adr |-> !pslverr; endproperty
  a_no_err: assert property (p_no_err) else $error("error on good address");
  property p_rd_bad; rd_setup && bad_adr |=> prdata == 32'h0000_0000; endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("bad address read not zero");
  property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_wr_zero; psel && !penable && pwrite |=> prdata == 32'h0000_0000; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write setup left read data");
  // ----------------------------------------
  // Field widths
  // ----------------------------------------
  property p_idx_w; rd_setup && paddr == AOS_OFF_ACC_INDEX |=> prdata[31:5] == 27'h000_0000; endproperty
  a_idx_w: assert property (p_idx_w) else $error("index wider than five bits");
  property p_mem_w; rd_setup && paddr == AOS_OFF_MEM_OPERAND |=> prdata[31:16] == 16'h0000; endproperty
  a_mem_w: assert property (p_mem_w) else $error("operand wider than sixteen bits");
  property p_stat_w;
    rd_setup && paddr == AOS_OFF_STATUS |=> prdata[31:21] == 11'h000 && prdata[15:13] == 3'h0;
  endproperty
  a_stat_w: assert property (p_stat_w) else $error("status index field too wide");
  property p_flag_w; rd_setup && paddr == AOS_OFF_FLAGS |=> prdata[31:13] == 19'h0_0000; endproperty
  a_flag_w: assert property (p_flag_w) else $error("flag word too wide");
  c_err: cover property (acc_ph && pslverr);
  c_stat: cover property (rd_setup && paddr == AOS_OFF_STATUS);
  c_instr: cover property (acc_ph && pwrite && paddr == AOS_OFF_INSTR);
endmodule
bind aos_decoder aos_decoder_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .in_line1(in_line1), .in_line2(in_line2)
);

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import aos_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, in_line1, in_line2, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int bad_count;
  int checked;
  logic [15:0] acc [32];
  logic [15:0] ap [4];
  logic [15:0] rr [4];
  logic [12:0] fl;
  aos_decoder dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_line1(in_line1), .in_line2(in_line2)
  );
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic exec(input logic [31:0] n);
    xfer(1, AOS_OFF_INSTR, n);
    do xfer(0, AOS_OFF_STATUS, 32'h0000_0000); while (q[0] !== 1'b0);
  endtask
  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic cnd(input int c, input logic [12:0] f);
    case (c)
      0: return f[0];
      1: return f[1];
      2: return f[2];
      3: return !f[0] && !f[2];
      4: return !f[0] && f[2];
      5: return f[0] && !f[1];
      6: return f[0] && !f[3];
      7: return f[3];
      8: return !f[0] && f[1];
      9: return f[4];
      10: return !f[5] && f[4];
      11: return f[5];
      12: return f[6];
      13: return f[7];
      14: return f[8];
      15: return f[11];
      16: return f[12];
      17: return f[9];
      18: return f[10];
      19: return !f[9] && !f[10];
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [9:0] pick(input logic [31:0] n, input logic [15:0] p);
    logic [4:0] a;
    logic [4:0] o;
    a = p[4:0];
    o = a + 5'h10;
    return {n[7] ? o : a, ((n[3:0] == 4'h2) ? !n[8] : n[6]) ? o : a};
  endfunction
  task summarize;
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    bad_count++;
    summarize();
  end
  initial begin
    logic [31:0] n;
    logic [15:0] mem;
    logic [15:0] fw;
    logic [16:0] sum;
    logic [9:0] pk;
    logic tk;
    int op, cc, sel, rs, sd;
    {psel, penable, pwrite, in_line1, in_line2} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 0;
    bad_count = 0;
    checked = 0;
    sd = $urandom(50);
    repeat (10) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a < 8'h38; a += 4) if (a != AOS_OFF_ACC_DATA) rdc(a[7:0], 32'h0000_0000);
    ap = '{default: 16'h0000};
    rr = '{default: 16'h0000};
    xfer(0, 8'h38, 32'h0000_0000);
    chk({q[31:1], err}, 32'h0000_0001);
    xfer(1, 8'h02, 32'h0000_0001);
    chk({31'h0, err}, 32'h0000_0001);
    for (int i = 0; i < 32; i++) begin
      acc[i] = $urandom;
      xfer(1, AOS_OFF_ACC_INDEX, i);
      xfer(1, AOS_OFF_ACC_DATA, {16'h0000, acc[i]});
    end
    for (int i = 0; i < 168; i++) begin
      op = i % 7;
      cc = (i / 7) % 24;
      n = $urandom;
      n[3:0] = op[3:0];
      n[16:12] = cc[4:0];
      n[11:10] = $urandom_range(0, 2);
      n[23:20] = $urandom_range(0, 12);
      n[27:24] = 4'h0;
      n[31:30] = 2'b00;
      sel = n[5:4];
      rs = n[29:28];
      ap[sel] = $urandom;
      rr[rs] = $urandom;
      mem = $urandom;
      fw = $urandom;
      in_line1 <= $urandom;
      in_line2 <= $urandom;
      xfer(1, AOS_OFF_AP0 + 8'(4 * sel), {16'h0000, ap[sel]});
      xfer(1, AOS_OFF_ADDR0 + 8'(4 * rs), {16'h0000, rr[rs]});
      xfer(1, AOS_OFF_MEM_OPERAND, {16'h0000, mem});
      xfer(1, AOS_OFF_FLAGS, {16'h0000, fw});
      fl = {in_line2, in_line1, fw[10:0]};
      pk = pick(n, ap[sel]);
      case (op)
        0: begin
          sum = {1'b0, acc[pk[9:5]]} + {1'b0, acc[pk[4:0]]};
          fl[3:0] = {(acc[pk[9:5]][15] == acc[pk[4:0]][15]) && (sum[15] != acc[pk[9:5]][15]),
            sum[16], sum[15], sum[15:0] == 16'h0000};
          acc[pk[9:5]] = sum[15:0];
        end
        1: acc[pk[9:5]] = n[9] ? {8'h00, mem[7:0]} : mem;
        2: acc[pk[9:5]] = acc[pk[4:0]];
        3: tk = cnd(cc, fl) ^ n[17];
        4: fl[6 + n[18]] = cnd(cc, fl) ^ n[17];
        5: fl[6 + n[18]] = fl[n[23:20]] ^ n[19];
        default: ;
      endcase
      if (n[11:10] == 2'b01) ap[sel] = ap[sel] + 16'h0001;
      if (n[11:10] == 2'b10) rr[rs] = rr[rs] + 16'h0001;
      exec(n);
      rdc(AOS_OFF_AP0 + 8'(4 * sel), {16'h0000, ap[sel]});
      rdc(AOS_OFF_ADDR0 + 8'(4 * rs), {16'h0000, rr[rs]});
      rdc(AOS_OFF_FLAGS, {19'h0_0000, fl});
      xfer(1, AOS_OFF_ACC_INDEX, {27'h000_0000, pk[9:5]});
      rdc(AOS_OFF_ACC_DATA, {16'h0000, acc[pk[9:5]]});
      pk = pick(n, ap[sel]);
      xfer(0, AOS_OFF_STATUS, 32'h0000_0000);
      chk({22'h00_0000, q[20:16], q[12:8]}, {22'h00_0000, pk});
      if (op == 3) chk({31'h0, q[1]}, {31'h0, tk});
    end
    summarize();
  end
endmodule
